// File: verilog/scru_pkg.sv
// Constants for the system clock ratio unit
`default_nettype none
package scru_pkg;
    // Multiplication field codes
    localparam logic [3:0] MulX2 = 4'h2;
    localparam logic [3:0] MulX5 = 4'h5;
    // Reset-config word low field positions
    localparam int SysMulLsb   = 0;
    localparam int CoreMulLsb  = 4;
    localparam int MemRatioPos = 11;
    localparam int LbRatioPos  = 12;
    localparam int RcwWidth    = 16;
    // Register offsets
    localparam logic [3:0] RegLbDivOfs = 4'h0;
    localparam logic [3:0] RegUnitOfs  = 4'h1;
    localparam logic [3:0] RegStatOfs  = 4'h2;
    localparam logic [3:0] RegCfgOfs   = 4'h3;
    // Reset values
    localparam logic [3:0] LbDivRst    = 4'h2;
    localparam logic [3:0] UnitDivRst  = 4'h1;
    localparam logic       UnitEnRst   = 1'b1;
    localparam logic [15:0] RcwHardRst = 16'h0502;
    // Clock rate
    localparam int RefClkMhz = 25;
    typedef enum logic [1:0] {ScruIdle, ScruLoad, ScruRun} scru_state_t;
endpackage
`default_nettype wire

// File: verilog/scru_top.sv
// System clock ratio unit: clock selection, ratio enables and control registers
// Behaviour
// - Host uses system input, agent peripheral clock
// - Host system input feeds divide-by-two sync
// - Divide-select picks undivided or halved sync
// - Bus clock equals sync times factors
// - Multiply codes 2..5 valid, others reserved
// - Multipliers loaded from reset config word
// - Memory clock ratio, halved for output
// - Memory data rate equals memory clock
// - Local-bus clock ratio, divided by field
// - Unit default ratio, software change or off
// - Host divide-select leaves bus ratio unchanged
//
// The register offsets and the strobed register port are this design's own decisions.
`default_nettype none
module scru_top
    import scru_pkg::*;
#(
    parameter int DivW = 4
)(
    // Clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       arst_n,
    // Configuration pins and reset word
    input  wire logic                       agentMode,
    input  wire logic                       inputDivideSelect,
    input  wire logic                       peripheralClockIn,
    input  wire logic                       useHardRcw,
    input  wire logic [scru_pkg::RcwWidth-1:0] resetConfigWordLow,
    // Register port
    input  wire logic [3:0]                 regAddr,
    input  wire logic [31:0]                regWrData,
    input  wire logic                       regWrite,
    input  wire logic                       regRead,
    output logic      [31:0]                regRdData,
    // Clock enables
    output logic                            syncOutEn,
    output logic                            busClkEn,
    output logic                            memClkEn,
    output logic                            memClkOut,
    output logic                            memDataEn,
    output logic                            localBusClkEn,
    output logic                            localBusClockOut,
    output logic                            unitClkEn,
    output logic                            configInvalid
);
    import scru_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers and reset-time capture
    // ------------------------------------------------------------
    logic [1:0] agentSync;
    logic [1:0] divSelSync;
    logic [1:0] pclkSync;
    logic       pclkPrev;
    scru_state_t stateQ;
    logic       agentQ;
    logic       divSelQ;
    logic [RcwWidth-1:0] rcwQ;
    logic       warmQ;

    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
        begin
            agentSync  <= 2'h0;
            divSelSync <= 2'h0;
            pclkSync   <= 2'h0;
            pclkPrev   <= 1'b0;
        end
        else
        begin
            agentSync  <= {agentSync[0], agentMode};
            divSelSync <= {divSelSync[0], inputDivideSelect};
            pclkSync   <= {pclkSync[0], peripheralClockIn};
            pclkPrev   <= pclkSync[1];
        end

    // Capture configuration once after reset release
    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
        begin
            stateQ  <= ScruIdle;
            agentQ  <= 1'b0;
            divSelQ <= 1'b0;
            rcwQ    <= '0;
            warmQ   <= 1'b0;
        end
        else
        begin
            case (stateQ)
                ScruIdle:
                begin
                    // Let both synchroniser stages fill before capture
                    warmQ <= 1'b1;
                    if (warmQ)
                        stateQ <= ScruLoad;
                end
                ScruLoad:
                begin
                    agentQ  <= agentSync[1];
                    divSelQ <= divSelSync[1];
                    rcwQ    <= useHardRcw ? RcwHardRst : resetConfigWordLow;
                    stateQ  <= ScruRun;
                end
                ScruRun: stateQ <= ScruRun;
                default: stateQ <= ScruIdle;
            endcase
        end

    logic       running;
    logic [3:0] sysMul;
    logic [6:0] coreMul;
    logic       memRatio;
    logic       lbRatio;
    logic       mulValid;
    assign running  = (stateQ == ScruRun);
    assign sysMul   = rcwQ[SysMulLsb +: 4];
    assign coreMul  = rcwQ[CoreMulLsb +: 7];
    assign memRatio = rcwQ[MemRatioPos];
    assign lbRatio  = rcwQ[LbRatioPos];
    assign mulValid = (sysMul >= MulX2) && (sysMul <= MulX5);

    // ------------------------------------------------------------
    // Primary clock tick and sync output
    // ------------------------------------------------------------
    // Host: ref_clk itself is the system input; agent: peripheral clock edges
    logic primTick;
    logic halfQ;
    logic syncTick;
    assign primTick = agentQ ? (pclkSync[1] & ~pclkPrev) : 1'b1;

    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            halfQ <= 1'b0;
        else if (running && primTick)
            halfQ <= ~halfQ;

    // Low select halves the sync clock, high passes it undivided
    assign syncTick = running && primTick && (divSelQ || halfQ);

    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            syncOutEn <= 1'b0;
        else
            syncOutEn <= syncTick;

    // ------------------------------------------------------------
    // Bus, memory and local-bus rate tracking
    // ------------------------------------------------------------
    // Bus ticks per sync tick = (1 + ~divSel) * mul; in host the sync
    // rate times that factor is the primary rate times mul alone.
    logic [4:0] busFactor;
    logic [4:0] busCredit;
    logic       busTick;
    assign busFactor = (agentQ && !divSelQ) ? {sysMul, 1'b0} : {1'b0, sysMul};
    assign busTick   = running && mulValid && (busCredit != 5'h0);

    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            busCredit <= 5'h0;
        else if (!running || !mulValid)
            busCredit <= 5'h0;
        else if ((agentQ ? syncTick : primTick) && busCredit == 5'h0)
            busCredit <= busFactor;
        else if (busTick)
            busCredit <= busCredit - 5'h1;

    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            busClkEn <= 1'b0;
        else
            busClkEn <= busTick;

    logic memTick;
    logic memPhaseQ;
    logic lbTick;
    assign memTick = busTick && (memRatio || memPhaseQ);
    assign lbTick  = busTick && (lbRatio  || memPhaseQ);

    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            memPhaseQ <= 1'b0;
        else if (busTick)
            memPhaseQ <= ~memPhaseQ;

    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
        begin
            memClkEn  <= 1'b0;
            memDataEn <= 1'b0;
            memClkOut <= 1'b0;
        end
        else
        begin
            memClkEn  <= memTick;
            memDataEn <= memTick;
            if (memTick)
                memClkOut <= ~memClkOut;
        end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [DivW-1:0] lbDivQ;
    logic [DivW-1:0] unitDivQ;
    logic            unitOnQ;

    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
        begin
            lbDivQ   <= DivW'(LbDivRst);
            unitDivQ <= DivW'(UnitDivRst);
            unitOnQ  <= UnitEnRst;
        end
        else if (regWrite)
        begin
            if (regAddr == RegLbDivOfs)
                lbDivQ <= regWrData[DivW-1:0];
            if (regAddr == RegUnitOfs)
            begin
                unitDivQ <= regWrData[DivW-1:0];
                unitOnQ  <= regWrData[8];
            end
        end

    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            regRdData <= 32'h0;
        else if (regRead)
        begin
            case (regAddr)
                RegLbDivOfs: regRdData <= 32'(lbDivQ);
                RegUnitOfs:  regRdData <= {23'h0, unitOnQ, 8'(unitDivQ)};
                RegStatOfs:  regRdData <= {28'h0, running, ~mulValid, divSelQ, agentQ};
                RegCfgOfs:   regRdData <= {9'h0, coreMul, 16'(rcwQ)};
                default:     regRdData <= 32'h0;
            endcase
        end
        else
            regRdData <= 32'h0;

    // ------------------------------------------------------------
    // Local-bus divider and unit clock divider
    // ------------------------------------------------------------
    logic [DivW-1:0] lbCntQ;
    logic [DivW-1:0] unitCntQ;
    logic            lbWrap;
    logic            unitWrap;
    assign lbWrap   = lbTick && (lbCntQ + DivW'(1) >= lbDivQ);
    assign unitWrap = busTick && (unitCntQ + DivW'(1) >= unitDivQ);

    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
        begin
            lbCntQ           <= '0;
            localBusClkEn    <= 1'b0;
            localBusClockOut <= 1'b0;
        end
        else
        begin
            localBusClkEn <= lbTick;
            if (lbTick)
                lbCntQ <= lbWrap ? '0 : lbCntQ + DivW'(1);
            if (lbWrap)
                localBusClockOut <= ~localBusClockOut;
        end

    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
        begin
            unitCntQ  <= '0;
            unitClkEn <= 1'b0;
        end
        else
        begin
            if (busTick)
                unitCntQ <= unitWrap ? '0 : unitCntQ + DivW'(1);
            unitClkEn <= unitOnQ && unitWrap;
        end

    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            configInvalid <= 1'b0;
        else
            configInvalid <= running && !mulValid;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_reserved_no_bus: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (running && !mulValid) |=> !busClkEn)
        else $error("bus clock ran on reserved multiplier");

    a_reserved_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (running && (sysMul < MulX2)) |=> configInvalid)
        else $error("reserved code not flagged");

    a_host_primary: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (running && !agentQ && mulValid && !busTick) |=> busTick)
        else $error("host primary tick missing");

    a_sync_halved: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (running && !agentQ && !divSelQ && syncTick) |=> !syncTick)
        else $error("halved sync ran back to back");

    a_sync_half_div: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (running && !agentQ && !divSelQ && !syncTick) |=> syncTick)
        else $error("divide by two sync missed");

    a_mem_data_rate: assert property (@(posedge ref_clk) disable iff (!arst_n)
        memDataEn == memClkEn)
        else $error("memory data rate differs from memory clock");

    a_mem_clk_toggle: assert property (@(posedge ref_clk) disable iff (!arst_n)
        memClkEn |-> (memClkOut != $past(memClkOut)))
        else $error("memory clock output did not toggle");

    a_unit_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!unitOnQ ##1 !unitOnQ) |-> !unitClkEn)
        else $error("unit clock ran while off");

    a_mem_ratio_one: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (busTick && memRatio) |=> memClkEn)
        else $error("memory enable missed bus tick");

    a_lb_within_bus: assert property (@(posedge ref_clk) disable iff (!arst_n)
        localBusClkEn |-> busClkEn)
        else $error("local bus tick outside bus tick");

    a_host_sync_full: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (running && !agentQ && divSelQ) |=> syncOutEn)
        else $error("undivided sync tick missing");

    a_cfg_held: assert property (@(posedge ref_clk) disable iff (!arst_n)
        running |=> $stable(rcwQ))
        else $error("reset config word changed while running");

    a_unit_full_rate: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (unitOnQ && (unitDivQ == DivW'(1)) && busTick) |=> unitClkEn)
        else $error("unit clock missed bus tick at ratio one");

endmodule
`default_nettype wire

// File: testbench/scru_board_clk.sv
// Board clock source model for the agent-role input clock
`default_nettype none
module scru_board_clk #(
    parameter int Half = 8
)(
    // Clock output
    output var logic pciClk
);
    timeunit 1ns;
    timeprecision 1ns;
    // Free-running board clock, offset from the bench clock
    initial
    begin
        pciClk = 1'b0;
        #13;
        forever #(Half * 40) pciClk = ~pciClk;
    end
endmodule
`default_nettype wire

// File: testbench/system_clock_ratio_unit_test.sv
// Self-checking bench for the system clock ratio unit
`default_nettype none
module system_clock_ratio_unit_test import scru_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk, arst_n, agentMode, divSel, useHard, regWrite, regRead;
    logic        syncEn, busEn, memEn, memOut, dataEn, lbEn, lbOut, unitEn, cfgBad, pm, pl;
    logic [15:0] w;
    logic [3:0]  regAddr;
    logic [31:0] regWrData, regRdData, seed, r;
    wire logic   pciClk;
    int          err_total, total_checks, on, b0, s0, d;
    int          c[8];
    int          muls[$] = {2, 3, 4, 5};
    int          rsv[$] = {0, 1, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15};

    scru_board_clk #(.Half(8)) board (.pciClk(pciClk));
    scru_top DUT (.ref_clk(ref_clk), .arst_n(arst_n), .agentMode(agentMode),
        .inputDivideSelect(divSel), .peripheralClockIn(pciClk), .useHardRcw(useHard),
        .resetConfigWordLow(w), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .syncOutEn(syncEn), .busClkEn(busEn), .memClkEn(memEn), .memClkOut(memOut),
        .memDataEn(dataEn), .localBusClkEn(lbEn), .localBusClockOut(lbOut),
        .unitClkEn(unitEn), .configInvalid(cfgBad));

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Tick and toggle counters, sampled mid-cycle
    always @(negedge ref_clk)
    begin
        if (on)
        begin
            c[0] += syncEn;
            c[1] += busEn;
            c[2] += memEn;
            c[3] += (memOut !== pm);
            c[4] += dataEn;
            c[5] += lbEn;
            c[6] += (lbOut !== pl);
            c[7] += unitEn;
        end
        pm = memOut;
        pl = lbOut;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic final_report();
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(string nm, int e, int g, int tol);
        total_checks++;
        if (g > e + tol || g < e - tol)
        begin
            err_total++;
            $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
        end
    endtask

    task automatic rd(logic [3:0] a, logic [31:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        total_checks++;
        if (regRdData !== e)
        begin
            err_total++;
            $display("unexpected read %h: expected %h, seen %h", a, e, regRdData);
        end
    endtask

    task automatic wr(logic [3:0] a, logic [31:0] dt);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= dt;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask

    task automatic rst(logic ag, logic ds, logic hw, logic [15:0] cw);
        @(posedge ref_clk);
        arst_n <= 1'b0;
        agentMode <= ag;
        divSel <= ds;
        useHard <= hw;
        w <= cw;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic meas(int n);
        @(posedge ref_clk);
        c = '{default: 0};
        on = 1;
        repeat (n) @(posedge ref_clk);
        on = 0;
    endtask

    initial
    begin
        repeat (60000) @(posedge ref_clk);
        err_total++;
        final_report();
    end

    initial
    begin
        {arst_n, agentMode, divSel, useHard, regWrite, regRead, on} = '0;
        {w, regAddr, regWrData, err_total, total_checks} = '0;
        seed = 32'h3cf96528;
        // Reset values and map
        rst(0, 1, 1, 16'h0);
        rd(RegStatOfs, 32'h0000000a);
        rd(RegCfgOfs, {9'h0, RcwHardRst[10:4], RcwHardRst});
        rd(RegLbDivOfs, {28'h0, LbDivRst});
        rd(RegUnitOfs, {23'h0, UnitEnRst, 4'h0, UnitDivRst});
        wr(4'h9, 32'hffffffff);
        rd(4'h9, 32'h0);
        // Host role ratios
        foreach (muls[i])
        begin
            r = xs();
            for (int ds = 0; ds < 2; ds++)
            begin
                rst(0, ds[0], 0, {3'h0, r[1:0], r[8:2], 4'(muls[i])});
                rd(RegCfgOfs, {9'h0, w[10:4], w});
                rd(RegStatOfs, {28'h0, 2'b10, ds[0], 1'b0});
                meas(400);
                if (ds == 0)
                begin
                    b0 = c[1];
                    s0 = c[0];
                end
                else
                begin
                    chk("host bus ticks", b0, c[1], 2);
                    chk("sync ticks", 2 * s0, c[0], 2);
                end
                chk("mem ticks", w[11] ? c[1] : c[1] / 2, c[2], 1);
                chk("mem data", c[2], c[4], 0);
                chk("mem toggles", c[2], c[3], 1);
                chk("lb ticks", w[12] ? c[1] : c[1] / 2, c[5], 1);
                chk("lb toggles", c[5] / 2, c[6], 1);
            end
        end
        // Agent role ratios
        foreach (muls[i])
            for (int ds = 0; ds < 2; ds++)
            begin
                rst(1, ds[0], 0, {12'h0, 4'(muls[i])});
                meas(800);
                chk("agent sync seen", 1, int'(c[0] > 10), 0);
                chk("agent bus", c[0] * muls[i] * (2 - ds), c[1], 2 * muls[i]);
            end
        // Reserved multiply codes
        foreach (rsv[i])
        begin
            rst(0, 1, 0, {12'h0, 4'(rsv[i])});
            @(negedge ref_clk);
            chk("invalid pin", 1, int'(cfgBad === 1'b1), 0);
        end
        // Software unit ratio and local-bus divide
        rst(0, 1, 0, 16'h1003);
        r = xs();
        d = int'(r[1:0]) + 2;
        wr(RegUnitOfs, 32'h100 | d);
        wr(RegLbDivOfs, d);
        rd(RegUnitOfs, 32'h100 | d);
        meas(600);
        chk("unit ticks", c[1] / d, c[7], 1);
        chk("lb divided", c[5] / d, c[6], 1);
        wr(RegUnitOfs, d);
        meas(200);
        chk("unit off", 0, c[7], 0);
        final_report();
    end
endmodule
`default_nettype wire
